// File: verilog/ref_clock_pkg.sv
// Purpose: Shared constants and types for the reference clock output and power-save block.
// Assumes: One 25 MHz clock; 16-bit registers behind a plain strobe port.
// Notes: Behaviour summary follows.

package ref_clock_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] REF_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] PWR_STAT_ADDR = 4'h2;

  localparam int REF_ENABLE_BIT = 15;
  localparam int REF_SLEEP_BIT = 13;
  localparam int REF_PRIMARY_BIT = 12;
  localparam int REF_DIV_LSB = 8;
  localparam int REF_DIV_W = 4;
  localparam logic [DATA_W-1:0] REF_CTRL_MASK = 16'hbf00;
  localparam logic [DATA_W-1:0] REF_CTRL_RESET = 16'h0000;

  localparam int REG_KEEP_BIT = 0;
  localparam int OSC_KEEP_BIT = 1;
  localparam logic REG_KEEP_RESET = 1'b1;
  localparam logic OSC_KEEP_RESET = 1'b0;

  localparam int CLOCK_MHZ = 25;
  localparam int REG_WAKE_US = 190;
  localparam int REG_WAKE_CYCLES = REG_WAKE_US * CLOCK_MHZ;
  localparam int WAKE_CNT_W = 16;
  localparam int SRC_W = 3;

  typedef enum logic [2:0]
  {
    PS_RUN = 3'b000,
    PS_ENTER = 3'b001,
    PS_SLEEP = 3'b010,
    PS_IDLE = 3'b011,
    PS_WAKE = 3'b100
  } ps_state_e;

endpackage : ref_clock_pkg

// File: verilog/ref_clock_divider.sv
// Purpose: Power-of-two divider for the reference clock output.
// Assumes: Base clock arrives as a level sampled on the system clock.
// Notes: Output is low from the first enabled clock after the divider is disabled.

`timescale 1ns/10ps

module ref_clock_divider #(
  parameter int DIV_W = 4,
  parameter int CNT_W = 15
) (
  // Clock, reset and freeze.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Control.
  input wire logic enable,
  input wire logic baseLevel,
  input wire logic [DIV_W-1:0] divisorSel,
  // Output.
  output logic clkOut
);

  logic baseLevel_r;
  logic [DIV_W-1:0] activeSel_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] halfLast;
  logic baseRise;

  assign baseRise = baseLevel & ~baseLevel_r;

  // Divide by 2**code toggles every 2**(code-1) base edges; code 2 gives two.
  always_comb
  begin
    halfLast = (CNT_W'(1) << (activeSel_r - DIV_W'(1))) - CNT_W'(1);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      baseLevel_r <= 1'b0;
    else if (clkEn)
      baseLevel_r <= baseLevel;
  end

  // A new divisor is taken while disabled, or otherwise only as the output is driven low: when a high half-period ends, or for code 0 while the base is low.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      activeSel_r <= '0;
      count_r <= '0;
      clkOut <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!enable)
      begin
        activeSel_r <= divisorSel;
        count_r <= '0;
        clkOut <= 1'b0;
      end
      else if (activeSel_r == '0)
      begin
        clkOut <= baseLevel;
        if (!baseLevel)
          activeSel_r <= divisorSel;
      end
      else if (baseRise)
      begin
        if (count_r == halfLast)
        begin
          count_r <= '0;
          clkOut <= ~clkOut;
          if (clkOut)
            activeSel_r <= divisorSel;
        end
        else
          count_r <= count_r + CNT_W'(1);
      end
    end
  end

endmodule : ref_clock_divider

// File: verilog/ref_clock_out_and_power_save.sv
// Purpose: Reference clock output and instruction-entered Sleep and Idle control.
// Assumes: Clock sources and wake events arrive as levels synchronous to clock.
// Notes: Register reads return data in the cycle after the read strobe.

`timescale 1ns/10ps

module ref_clock_out_and_power_save #(
  parameter int REG_WAKE_CYCLES = ref_clock_pkg::REG_WAKE_CYCLES
) (
  // Clock, reset and freeze.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clkEn,
  // Register port.
  input wire logic [ref_clock_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ref_clock_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [ref_clock_pkg::DATA_W-1:0] regRdData,
  // Power-save instruction from the core.
  input wire logic powerSaveInstr,
  input wire logic powerSaveOperand,
  // Wake sources and configuration.
  input wire logic irqPending,
  input wire logic watchdogTimeout,
  input wire logic watchdogEnable,
  input wire logic failsafeEnable,
  input wire logic primaryOscMode,
  input wire logic [ref_clock_pkg::SRC_W-1:0] nextClockSourceSel,
  // Clock sources seen as levels.
  input wire logic sysClockLevel,
  input wire logic primaryOscLevel,
  // Clock and power controls.
  output logic cpuClockEnable,
  output logic sysClockRun,
  output logic onChipOscRun,
  output logic periphClockEnable,
  output logic primaryOscRun,
  output logic lowPowerRcRun,
  output logic failsafeRun,
  output logic regulatorStandby,
  output logic watchdogClear,
  output logic wakeResume,
  output logic [ref_clock_pkg::SRC_W-1:0] activeClockSource,
  // Reference clock pin.
  output logic refClockPin,
  output logic refClockOe
);

  ////////////////////////////////////////////////////////////////////////////////

  logic refEnable_r;
  logic runInSleep_r;
  logic sourcePrimary_r;
  logic [ref_clock_pkg::REF_DIV_W-1:0] divisorSel_r;
  logic regKeep_r;
  logic oscKeep_r;
  logic [ref_clock_pkg::DATA_W-1:0] rdData_r;
  logic [ref_clock_pkg::DATA_W-1:0] rdNxt;
  logic [ref_clock_pkg::DATA_W-1:0] refCtrlView;

  ref_clock_pkg::ps_state_e state_r;
  ref_clock_pkg::ps_state_e stateNxt;
  logic modeIdle_r;
  logic heldWake_r;
  logic wakeResume_r;
  logic [ref_clock_pkg::WAKE_CNT_W-1:0] wakeCount_r;
  logic [ref_clock_pkg::SRC_W-1:0] savedSource_r;
  logic wakeEvent;
  logic sleeping;
  logic refActive;
  logic baseLevel;
  logic regWriteCtrl;
  logic regWritePwr;

  assign regWriteCtrl = regWrEn && regAddr == ref_clock_pkg::REF_CTRL_ADDR;
  assign regWritePwr = regWrEn && regAddr == ref_clock_pkg::PWR_CTRL_ADDR;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      refEnable_r <= ref_clock_pkg::REF_CTRL_RESET[ref_clock_pkg::REF_ENABLE_BIT];
      runInSleep_r <= ref_clock_pkg::REF_CTRL_RESET[ref_clock_pkg::REF_SLEEP_BIT];
      sourcePrimary_r <= ref_clock_pkg::REF_CTRL_RESET[ref_clock_pkg::REF_PRIMARY_BIT];
      divisorSel_r <= '0;
    end
    else if (clkEn && regWriteCtrl)
    begin
      refEnable_r <= regWrData[ref_clock_pkg::REF_ENABLE_BIT];
      runInSleep_r <= regWrData[ref_clock_pkg::REF_SLEEP_BIT];
      sourcePrimary_r <= regWrData[ref_clock_pkg::REF_PRIMARY_BIT];
      divisorSel_r <= regWrData[ref_clock_pkg::REF_DIV_LSB +: ref_clock_pkg::REF_DIV_W];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      regKeep_r <= ref_clock_pkg::REG_KEEP_RESET;
      oscKeep_r <= ref_clock_pkg::OSC_KEEP_RESET;
    end
    else if (clkEn && regWritePwr)
    begin
      regKeep_r <= regWrData[ref_clock_pkg::REG_KEEP_BIT];
      oscKeep_r <= regWrData[ref_clock_pkg::OSC_KEEP_BIT];
    end
  end

  // Unimplemented control bits are simply never stored, so they read zero.
  always_comb
  begin
    refCtrlView = '0;
    refCtrlView[ref_clock_pkg::REF_ENABLE_BIT] = refEnable_r;
    refCtrlView[ref_clock_pkg::REF_SLEEP_BIT] = runInSleep_r;
    refCtrlView[ref_clock_pkg::REF_PRIMARY_BIT] = sourcePrimary_r;
    refCtrlView[ref_clock_pkg::REF_DIV_LSB +: ref_clock_pkg::REF_DIV_W] = divisorSel_r;
  end

  always_comb
  begin
    rdNxt = '0;
    case (regAddr)
      ref_clock_pkg::REF_CTRL_ADDR:
        rdNxt = refCtrlView & ref_clock_pkg::REF_CTRL_MASK;
      ref_clock_pkg::PWR_CTRL_ADDR:
      begin
        rdNxt[ref_clock_pkg::REG_KEEP_BIT] = regKeep_r;
        rdNxt[ref_clock_pkg::OSC_KEEP_BIT] = oscKeep_r;
      end
      ref_clock_pkg::PWR_STAT_ADDR:
        rdNxt = {8'h00, heldWake_r, refActive, modeIdle_r, 2'b00, state_r};
      default:
        rdNxt = '0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdData_r <= '0;
    else if (clkEn)
      rdData_r <= regRdEn ? rdNxt : '0;
  end

  assign regRdData = rdData_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Power-save sequencer.

  assign wakeEvent = irqPending | watchdogTimeout;
  assign sleeping = state_r == ref_clock_pkg::PS_SLEEP || state_r == ref_clock_pkg::PS_WAKE;

  always_comb
  begin
    stateNxt = state_r;
    case (state_r)
      ref_clock_pkg::PS_RUN:
        if (powerSaveInstr)
          stateNxt = ref_clock_pkg::PS_ENTER;
      ref_clock_pkg::PS_ENTER:
        stateNxt = modeIdle_r ? ref_clock_pkg::PS_IDLE : ref_clock_pkg::PS_SLEEP;
      ref_clock_pkg::PS_SLEEP:
        if (wakeEvent || heldWake_r)
          stateNxt = regKeep_r ? ref_clock_pkg::PS_RUN : ref_clock_pkg::PS_WAKE;
      ref_clock_pkg::PS_IDLE:
        if (wakeEvent || heldWake_r)
          stateNxt = ref_clock_pkg::PS_RUN;
      ref_clock_pkg::PS_WAKE:
        if (wakeCount_r == '0)
          stateNxt = ref_clock_pkg::PS_RUN;
      default:
        stateNxt = ref_clock_pkg::PS_RUN;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      state_r <= ref_clock_pkg::PS_RUN;
    else if (clkEn)
      state_r <= stateNxt;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      modeIdle_r <= 1'b0;
    else if (clkEn && state_r == ref_clock_pkg::PS_RUN && powerSaveInstr)
      modeIdle_r <= powerSaveOperand;
  end

  // Wake events seen while entering are kept and acted on once the mode is reached.
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      heldWake_r <= 1'b0;
    else if (clkEn)
    begin
      if ((state_r == ref_clock_pkg::PS_RUN && powerSaveInstr) ||
          state_r == ref_clock_pkg::PS_ENTER)
        heldWake_r <= heldWake_r | wakeEvent;
      else if (state_r != ref_clock_pkg::PS_RUN && stateNxt != state_r)
        heldWake_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      wakeCount_r <= '0;
    else if (clkEn)
    begin
      if (state_r == ref_clock_pkg::PS_SLEEP)
        wakeCount_r <= ref_clock_pkg::WAKE_CNT_W'(REG_WAKE_CYCLES - 1);
      else if (state_r == ref_clock_pkg::PS_WAKE && wakeCount_r != '0)
        wakeCount_r <= wakeCount_r - ref_clock_pkg::WAKE_CNT_W'(1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      savedSource_r <= '0;
    else if (clkEn && state_r == ref_clock_pkg::PS_RUN)
      savedSource_r <= nextClockSourceSel;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      wakeResume_r <= 1'b0;
    else if (clkEn)
      wakeResume_r <= state_r != ref_clock_pkg::PS_RUN &&
                      state_r != ref_clock_pkg::PS_ENTER &&
                      stateNxt == ref_clock_pkg::PS_RUN;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and power controls.

  assign cpuClockEnable = state_r == ref_clock_pkg::PS_RUN ||
                          state_r == ref_clock_pkg::PS_ENTER;
  assign sysClockRun = !sleeping;
  assign onChipOscRun = !sleeping;
  assign periphClockEnable = !sleeping;
  assign primaryOscRun = primaryOscMode && (!sleeping || oscKeep_r);
  assign lowPowerRcRun = sleeping ? watchdogEnable : (watchdogEnable | failsafeEnable);
  assign failsafeRun = failsafeEnable && !sleeping;
  assign regulatorStandby = sleeping && !regKeep_r;
  assign watchdogClear = state_r == ref_clock_pkg::PS_ENTER;
  assign wakeResume = wakeResume_r;
  assign activeClockSource = state_r == ref_clock_pkg::PS_RUN ?
                             nextClockSourceSel : savedSource_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference clock output.

  assign refActive = refEnable_r &&
                     (!sleeping || (runInSleep_r && sourcePrimary_r && primaryOscRun));
  assign baseLevel = sourcePrimary_r ? (primaryOscLevel & primaryOscRun) :
                     (sysClockLevel & sysClockRun);

  ref_clock_divider #(
    .DIV_W(ref_clock_pkg::REF_DIV_W),
    .CNT_W(15)
  ) divider (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .enable(refActive),
    .baseLevel(baseLevel),
    .divisorSel(divisorSel_r),
    .clkOut(refClockPin)
  );

  assign refClockOe = refEnable_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  instr_enter_a: assert property (
    state_r == ref_clock_pkg::PS_RUN && powerSaveInstr && clkEn
    |=> state_r == ref_clock_pkg::PS_ENTER && watchdogClear)
    else $error("power-save instruction did not start entry");

  mode_select_a: assert property (
    state_r == ref_clock_pkg::PS_ENTER && clkEn
    |=> state_r == (modeIdle_r ? ref_clock_pkg::PS_IDLE : ref_clock_pkg::PS_SLEEP))
    else $error("entry went to the wrong low-power mode");

  watchdog_clear_a: assert property (
    $rose(state_r == ref_clock_pkg::PS_SLEEP || state_r == ref_clock_pkg::PS_IDLE)
    |-> $past(watchdogClear))
    else $error("low-power mode entered without a watchdog clear");

  sleep_clocks_a: assert property (
    state_r == ref_clock_pkg::PS_SLEEP
    |-> !sysClockRun && !cpuClockEnable && !periphClockEnable && !onChipOscRun)
    else $error("clocks still running in Sleep");

  idle_clocks_a: assert property (
    state_r == ref_clock_pkg::PS_IDLE |-> !cpuClockEnable && sysClockRun && periphClockEnable)
    else $error("Idle clock gating wrong");

  low_power_rc_clock_keep_a: assert property (
    (state_r == ref_clock_pkg::PS_SLEEP |-> lowPowerRcRun == watchdogEnable) and
    (state_r == ref_clock_pkg::PS_IDLE |-> lowPowerRcRun == (watchdogEnable || failsafeEnable)))
    else $error("low-power RC oscillator state wrong");

  monitor_sleep_a: assert property (
    sleeping |-> !failsafeRun)
    else $error("clock monitor running in Sleep");

  idle_wake_a: assert property (
    state_r == ref_clock_pkg::PS_IDLE && wakeEvent && clkEn
    |=> state_r == ref_clock_pkg::PS_RUN && cpuClockEnable && wakeResume)
    else $error("Idle did not wake at once");

  regulator_wake_a: assert property (
    state_r == ref_clock_pkg::PS_SLEEP && wakeEvent && !regKeep_r && clkEn
    |=> state_r == ref_clock_pkg::PS_WAKE && regulatorStandby)
    else $error("regulator wake delay skipped");

  held_wake_a: assert property (
    state_r == ref_clock_pkg::PS_ENTER && wakeEvent && clkEn
    |=> heldWake_r && state_r != ref_clock_pkg::PS_RUN)
    else $error("coincident interrupt not held off");

  source_resume_a: assert property (
    sleeping |-> activeClockSource == savedSource_r && $stable(savedSource_r))
    else $error("clock source changed across Sleep");

  sleep_ref_a: assert property (
    sleeping && !(runInSleep_r && sourcePrimary_r) |-> !refActive)
    else $error("reference output active in Sleep");

  ref_off_low_a: assert property (
    !refActive && clkEn ##1 !refActive |-> !refClockPin)
    else $error("disabled reference output not low");

  ctrl_rsvd_a: assert property (
    $past(regRdEn && regAddr == ref_clock_pkg::REF_CTRL_ADDR && clkEn)
    |-> (regRdData & ~ref_clock_pkg::REF_CTRL_MASK) == '0)
    else $error("reserved control bits read nonzero");

  sleep_wake_c: cover property (
    state_r == ref_clock_pkg::PS_SLEEP ##1 state_r == ref_clock_pkg::PS_RUN);
  idle_wake_c: cover property (
    state_r == ref_clock_pkg::PS_IDLE ##1 state_r == ref_clock_pkg::PS_RUN);
  reg_delay_c: cover property (
    state_r == ref_clock_pkg::PS_WAKE ##1 state_r == ref_clock_pkg::PS_RUN);
  ref_sleep_c: cover property (sleeping && refActive && refClockPin);

endmodule : ref_clock_out_and_power_save

// File: dv/ref_clock_listener.sv
// Purpose: External device clocked from the reference clock pin.
// Assumes: The pin is sampled on the system clock; a released pin reads low.
// Notes: Reports the last period, the rise count and the shortest high pulse ending after the restart.

`timescale 1ns/10ps

module ref_clock_listener (
  // Clock, reset and statistics restart.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic statsClear,
  // Reference pin.
  input wire logic refClockPin,
  input wire logic refClockOe,
  // Measurements.
  output int period,
  output int riseCount,
  output int minHigh
);

  logic pinPrev;
  logic pinSeen;
  logic armed;
  int sinceRise;
  int highLen;

  ////////////////////////////////////////////////////////////////////////////////
  // The pull-down on the board holds the line low while the pin is not driven.
  assign pinSeen = refClockOe & refClockPin;

  always @(posedge clock)
  begin
    if (!rst_b || statsClear)
    begin
      pinPrev <= 1'b0;
      armed <= 1'b0;
      sinceRise <= 0;
      highLen <= 0;
      period <= 0;
      riseCount <= 0;
      minHigh <= 255;
    end
    else
    begin
      pinPrev <= pinSeen;
      sinceRise <= sinceRise + 1;
      highLen <= pinSeen ? highLen + 1 : 0;
      if (pinSeen && !pinPrev)
      begin
        period <= sinceRise;
        sinceRise <= 1;
        riseCount <= riseCount + 1;
        armed <= 1'b1;
      end
      // A pulse already high at the restart also counts, measured from its first high sample after the restart.
      if (!pinSeen && pinPrev && armed && highLen < minHigh)
        minHigh <= highLen;
    end
  end

endmodule : ref_clock_listener

// File: dv/ref_clock_out_and_power_save_bench.sv
// Purpose: Self-checking bench for the reference clock output and power-save block.
// Assumes: 25 MHz clock; registers reached through the plain strobe port.
// Notes: The regulator wake wait is shortened to WAKE_N cycles.

`timescale 1ns/10ps

module ref_clock_out_and_power_save_bench;

  localparam int WAKE_N = 8;
  localparam logic [3:0] REF_A = ref_clock_pkg::REF_CTRL_ADDR;
  localparam logic [3:0] PWR_A = ref_clock_pkg::PWR_CTRL_ADDR;

  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [15:0] regRdData;
  logic psInstr = 1'b0;
  logic psOp = 1'b0;
  logic irqPending = 1'b0;
  logic wdTimeout = 1'b0;
  logic wdEnable = 1'b0;
  logic fsEnable = 1'b1;
  logic oscMode = 1'b1;
  logic [2:0] srcSel = 3'h2;
  logic sysLevel = 1'b0;
  logic oscLevel = 1'b0;
  logic oscDiv = 1'b0;
  logic statsClear = 1'b0;
  logic clkEn = 1'b1;
  logic cpuEn, sysRun, oscRun, perEn, primRun, lprcRun, fsRun, regStby, wdClear, wake, pin, oe;
  logic [2:0] actSrc;
  int period, riseCount, minHigh;
  int nMismatch = 0;
  int numChecks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////////
  always #20 clock = ~clock;

  // Clock sources run only while the block lets them.
  always @(posedge clock)
  begin
    if (sysRun === 1'b1)
      sysLevel <= ~sysLevel;
    if (primRun === 1'b1)
      oscDiv <= ~oscDiv;
    if (primRun === 1'b1 && oscDiv)
      oscLevel <= ~oscLevel;
  end

  ref_clock_out_and_power_save #(.REG_WAKE_CYCLES(WAKE_N)) i_dut (
    .clock(clock), .rst_b(rst_b), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .powerSaveInstr(psInstr), .powerSaveOperand(psOp),
    .irqPending(irqPending), .watchdogTimeout(wdTimeout), .watchdogEnable(wdEnable),
    .failsafeEnable(fsEnable), .primaryOscMode(oscMode), .nextClockSourceSel(srcSel),
    .sysClockLevel(sysLevel), .primaryOscLevel(oscLevel), .cpuClockEnable(cpuEn),
    .sysClockRun(sysRun), .onChipOscRun(oscRun), .periphClockEnable(perEn),
    .primaryOscRun(primRun), .lowPowerRcRun(lprcRun), .failsafeRun(fsRun),
    .regulatorStandby(regStby), .watchdogClear(wdClear), .wakeResume(wake),
    .activeClockSource(actSrc), .refClockPin(pin), .refClockOe(oe));

  ref_clock_listener i_listener (
    .clock(clock), .rst_b(rst_b), .statsClear(statsClear), .refClockPin(pin),
    .refClockOe(oe), .period(period), .riseCount(riseCount), .minHigh(minHigh));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic print_verdict();
    if (nMismatch == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdEn <= 1'b0;
    @(negedge clock);
    check(name, exp, regRdData);
  endtask : regRead

  task automatic clearStats();
    @(posedge clock);
    statsClear <= 1'b1;
    @(posedge clock);
    statsClear <= 1'b0;
  endtask : clearStats

  task automatic measure(input logic [15:0] ctrl, input int exp);
    // Disabling first restarts the divider, so a slow old divisor cannot delay the new one.
    regWrite(REF_A, ctrl & 16'h7fff);
    regWrite(REF_A, ctrl);
    @(negedge clock);
    check("ref enable", 16'h0001, {15'h0000, oe});
    clearStats();
    repeat (4 * exp + 8) @(posedge clock);
    @(negedge clock);
    check("ref period", 16'(exp), 16'(period));
  endtask : measure

  // A held wake request may coincide with the entry cycle.
  task automatic enterMode(input logic op, input logic hold);
    @(posedge clock);
    psInstr <= 1'b1;
    psOp <= op;
    @(posedge clock);
    psInstr <= 1'b0;
    irqPending <= hold;
    @(negedge clock);
    check("watchdog clear", 16'h0003, {14'h0000, wdClear, cpuEn});
    @(posedge clock);
    irqPending <= 1'b0;
    @(negedge clock);
    check("cpu clock in mode", 16'h0000, {15'h0000, cpuEn});
  endtask : enterMode

  // Source 0 raises an interrupt, 1 a watchdog time-out, 2 nothing.
  task automatic wakeBy(input int src, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clock);
    irqPending <= (src == 0);
    wdTimeout <= (src == 1);
    while (wake !== 1'b1 && n < 50)
    begin
      @(negedge clock);
      n++;
    end
    check("wake delay", 16'h0001, {15'h0000, n >= lo && n <= hi});
    check("cpu clock on wake", 16'h0001, {15'h0000, cpuEn});
    @(posedge clock);
    irqPending <= 1'b0;
    wdTimeout <= 1'b0;
  endtask : wakeBy

  task automatic sleepRef(input logic [15:0] ctrl, input logic expRun);
    regWrite(REF_A, ctrl);
    enterMode(1'b0, 1'b0);
    repeat (4) @(posedge clock);
    clearStats();
    repeat (40) @(posedge clock);
    @(negedge clock);
    check("ref runs in sleep", {15'h0000, expRun}, {15'h0000, riseCount > 0});
    wakeBy(0, 2, 2);
  endtask : sleepRef

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      nMismatch++;
      print_verdict();
    end
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    regRead(REF_A, ref_clock_pkg::REF_CTRL_RESET, "ref control reset");
    regRead(PWR_A, 16'h0001, "power control reset");
    regWrite(REF_A, 16'hffff);
    regRead(REF_A, 16'hbf00, "ref control mask");
    regRead(4'hf, 16'h0000, "unmapped read");
    for (int c = 0; c < 6; c++)
      measure(16'h8000 | 16'(c << 8), 2 << c);
    measure(16'h9100, 8);
    measure(16'h8300, 16);
    clearStats();
    regWrite(REF_A, 16'h8100);
    repeat (40) @(posedge clock);
    @(negedge clock);
    check("short high pulse", 16'h0001, {15'h0000, minHigh >= 2});
    regWrite(REF_A, 16'h0000);
    repeat (4) @(posedge clock);
    @(negedge clock);
    check("disabled pin", 16'h0000, {14'h0000, pin, oe});
    enterMode(1'b1, 1'b0);
    check("idle clocks", 16'h000f, {12'h000, sysRun, perEn, lprcRun, fsRun});
    wakeBy(0, 2, 2);
    enterMode(1'b1, 1'b1);
    wakeBy(2, 1, 2);
    wdEnable <= 1'b1;
    enterMode(1'b0, 1'b0);
    check("sleep clocks", 16'h0000, {12'h000, sysRun, oscRun, perEn, fsRun});
    check("sleep rc and regulator", 16'h0002, {14'h0000, lprcRun, regStby});
    @(posedge clock);
    srcSel <= 3'h5;
    @(negedge clock);
    check("saved clock source", 16'h0002, {13'h0000, actSrc});
    @(posedge clock);
    srcSel <= 3'h2;
    wakeBy(1, 2, 2);
    wdEnable <= 1'b0;
    regWrite(PWR_A, 16'h0000);
    enterMode(1'b0, 1'b0);
    check("standby rc", 16'h0001, {14'h0000, lprcRun, regStby});
    wakeBy(0, WAKE_N + 2, WAKE_N + 3);
    regWrite(PWR_A, 16'h0003);
    sleepRef(16'hb100, 1'b1);
    sleepRef(16'h9100, 1'b0);
    sleepRef(16'ha100, 1'b0);
    regWrite(PWR_A, 16'h0001);
    sleepRef(16'hb100, 1'b0);
    // A frozen block must ignore a power-save instruction.
    @(posedge clock);
    clkEn <= 1'b0;
    psInstr <= 1'b1;
    @(posedge clock);
    psInstr <= 1'b0;
    @(negedge clock);
    check("frozen entry", 16'h0001, {14'h0000, wdClear, cpuEn});
    @(posedge clock);
    clkEn <= 1'b1;
    // A reset in Sleep wakes the block and restores the register defaults.
    enterMode(1'b0, 1'b0);
    @(posedge clock);
    rst_b <= 1'b0;
    @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    check("reset wakes", 16'h0001, {15'h0000, cpuEn});
    regRead(PWR_A, 16'h0001, "power control after reset");
    regRead(REF_A, ref_clock_pkg::REF_CTRL_RESET, "ref control after reset");
    print_verdict();
  end

endmodule : ref_clock_out_and_power_save_bench
